// >>> flash_seq_defs.vh
// Constants for the flash program sequencer: register map, command codes, timing.
// Assumes a 100 MHz clock and a x16 parallel flash with word addressing.
`ifndef FLASH_SEQ_DEFS_VH
`define FLASH_SEQ_DEFS_VH
`define CLK_NS 10
// Register offsets on the local port
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_COUNT 8'h0c
`define REG_BUF 8'h10
`define REG_STATUS 8'h14
`define REG_POLL 8'h18
// Control bits
`define CTRL_WORD 0
`define CTRL_BUF 1
`define CTRL_ABRT 2
`define CTRL_HRST 3
`define CTRL_SUSP 4
`define CTRL_RES 5
`define CTRL_CLR 6
`define CTRL_ASP 8
// Flash command words
`define UNLOCK1_ADDR 26'h0000555
`define UNLOCK2_ADDR 26'h00002aa
`define UNLOCK1_DATA 16'h00aa
`define UNLOCK2_DATA 16'h0055
`define CMD_PROGRAM 16'h00a0
`define CMD_TO_BUFFER 16'h0025
`define CMD_CONFIRM 16'h0029
`define CMD_RESET 16'h00f0
`define CMD_SUSPEND 16'h0051
`define CMD_RESUME 16'h0050
`define CMD_CLR_STATUS 16'h0071
// Line of 512 bytes: 256 words
`define LINE_LAST 9'h0ff
// Data polling bits
`define POLL_ABORT_BIT 1
`define POLL_TIMEOUT_BIT 5
// Bus cycle timing in ns, and derived cycle counts
`define T_WP_NS 50
`define T_WPH_NS 30
`define T_ACC_NS 100
`define T_BUSY_NS 100
`define T_RP_NS 200
`define RESET_RECOVERY_TIME_NS 35000
`define T_WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WPH_CYC ((`T_WPH_NS + `CLK_NS - 1) / `CLK_NS)
`define T_ACC_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define T_BUSY_CYC ((`T_BUSY_NS + `CLK_NS - 1) / `CLK_NS)
`define T_RP_CYC ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define RESET_RECOVERY_TIME_CYC ((`RESET_RECOVERY_TIME_NS + `CLK_NS - 1) / `CLK_NS)
// Synchroniser latency added to every read strobe
`define SYNC_LAT 3
`define PROG_TIMEOUT_US 3000
`endif

// >>> pin_sync.v
// Three-stage synchroniser for the flash data bus and ready/busy pin.
// Assumes inputs are asynchronous to clk; output moves once stages two and three agree.
`timescale 1ns/1ns
module pin_sync (
  input wire clk,
  input wire rst,
  input wire [16:0] pin_in,
  output reg [16:0] pin_out
);
  reg [16:0] s1_reg;
  reg [16:0] s2_reg;
  reg [16:0] s3_reg;
  // Shift chain, first stage read only by second
  always @(posedge clk) begin
    if (rst) begin
      s1_reg <= 17'h1ffff;
      s2_reg <= 17'h1ffff;
      s3_reg <= 17'h1ffff;
      pin_out <= 17'h1ffff;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        pin_out <= s3_reg;
      end
    end
  end
endmodule // pin_sync

// >>> bus_cycle_gen.v
// One asynchronous flash bus cycle: write strobe or read with data capture.
// Assumes dq_sync is the synchronised data bus, lagging the pins by four cycles, one more than SYNC_LAT.
`timescale 1ns/1ns
`include "flash_seq_defs.vh"
module bus_cycle_gen (
  input wire clk,
  input wire rst,
  input wire start,
  input wire wr,
  input wire [25:0] addr,
  input wire [15:0] wdata,
  input wire [15:0] dq_sync,
  output wire ready,
  output reg done,
  output reg [15:0] rdata,
  output reg [25:0] flash_addr,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg [15:0] flash_dq_out,
  output reg flash_dq_oe
);
  localparam P_IDLE = 2'd0;
  localparam P_SETUP = 2'd1;
  localparam P_STROBE = 2'd2;
  localparam P_HOLD = 2'd3;
  // Last count value of each timed phase
  localparam [7:0] WP_LAST = `T_WP_CYC - 1;
  localparam [7:0] RD_LAST = `T_ACC_CYC + `SYNC_LAT - 1;
  localparam [7:0] WPH_LAST = `T_WPH_CYC - 1;
  reg [1:0] phase_reg;
  reg [7:0] cnt_reg;
  reg wr_reg;
  assign ready = (phase_reg == P_IDLE);
  // Phase sequencer driving the pins
  always @(posedge clk) begin
    if (rst) begin
      phase_reg <= P_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      flash_addr <= 26'h0000000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 16'h0000;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase_reg)
        P_IDLE: begin
          if (start) begin
            flash_addr <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe <= wr;
            flash_ce_n <= 1'b0;
            wr_reg <= wr;
            phase_reg <= P_SETUP;
          end
        end
        P_SETUP: begin
          flash_we_n <= ~wr_reg;
          flash_oe_n <= wr_reg;
          cnt_reg <= wr_reg ? WP_LAST : RD_LAST;
          phase_reg <= P_STROBE;
        end
        P_STROBE: begin
          if (cnt_reg == 8'h00) begin
            if (!wr_reg) begin
              rdata <= dq_sync;
            end
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_reg <= WPH_LAST;
            phase_reg <= P_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: begin
          flash_ce_n <= 1'b1;
          if (cnt_reg == 8'h00) begin
            flash_dq_oe <= 1'b0;
            done <= 1'b1;
            phase_reg <= P_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
      endcase
    end
  end
endmodule // bus_cycle_gen

// >>> flash_program_command_sequencer.v
// Host-side sequencer that programs a parallel NOR flash by word or by write buffer.
// Assumes software on a plain register port; flash pins are asynchronous.
`timescale 1ns/1ns
`include "flash_seq_defs.vh"
module flash_program_command_sequencer #(
  parameter [19:0] TIMEOUT_CYC = `PROG_TIMEOUT_US * (1000 / `CLK_NS)
) (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output wire [25:0] flash_addr,
  output wire flash_ce_n,
  output wire flash_oe_n,
  output wire flash_we_n,
  output reg flash_reset_n,
  output wire [15:0] flash_dq_out,
  output wire flash_dq_oe,
  input wire [15:0] flash_dq_in,
  input wire ready_busy_n
);
  localparam S_IDLE = 3'd0;
  localparam S_CMD = 3'd1;
  localparam S_LOAD = 3'd2;
  localparam S_CONF = 3'd3;
  localparam S_BUSY = 3'd4;
  localparam S_POLL = 3'd5;
  localparam S_HRST = 3'd6;
  localparam S_HREC = 3'd7;
  localparam K_WORD = 3'd0;
  localparam K_BUF = 3'd1;
  localparam K_ABRT = 3'd2;
  localparam K_RST = 3'd3;
  localparam K_SUSP = 3'd4;
  localparam K_RES = 3'd5;
  localparam K_CLR = 3'd6;
  localparam [19:0] BUSY_SETTLE = `T_BUSY_CYC;
  localparam [19:0] RP_LAST = `T_RP_CYC - 1;
  localparam [19:0] RPH_LAST = `RESET_RECOVERY_TIME_CYC - 1;

  reg [2:0] state_reg;
  reg [2:0] kind_reg;
  reg [1:0] step_reg;
  reg [7:0] idx_reg;
  reg [19:0] cnt_reg;
  reg launched_reg;
  reg asp_reg;
  reg suspended_reg;
  reg [25:0] tgt_reg;
  reg [15:0] data_reg;
  reg [7:0] count_reg;
  reg [7:0] wptr_reg;
  reg [15:0] poll_reg;
  reg st_done_reg;
  reg st_abort_reg;
  reg st_fail_reg;
  reg st_refused_reg;
  reg st_reset_reg;
  reg st_interrupted_reg;
  reg [15:0] buf_mem [0:255];
  wire [16:0] synced;
  wire rb_sync;
  wire [15:0] dq_sync;
  wire op_ready;
  wire op_done;
  wire [15:0] op_rdata;
  reg op_start;
  reg op_wr;
  reg [25:0] op_addr;
  reg [15:0] op_wdata;
  wire [41:0] cmd_pair;
  wire last_step;
  wire busy;
  wire ctrl_wr;
  wire line_ok;

  // Address and data of each command step
  function [41:0] cmd_word;
    input [2:0] kind;
    input [1:0] step;
    input asp;
    input [25:0] tgt;
    input [15:0] data;
    input [7:0] count;
    reg [1:0] eff;
    begin
      eff = (kind == K_WORD && asp) ? step + 2'd2 : step;
      cmd_word = {tgt, data};
      if (kind == K_RST) begin
        cmd_word = {tgt, `CMD_RESET};
      end else if (kind == K_SUSP) begin
        cmd_word = {tgt, `CMD_SUSPEND};
      end else if (kind == K_RES) begin
        cmd_word = {tgt, `CMD_RESUME};
      end else if (kind == K_CLR) begin
        cmd_word = {`UNLOCK1_ADDR, `CMD_CLR_STATUS};
      end else if (eff == 2'd0) begin
        cmd_word = {`UNLOCK1_ADDR, `UNLOCK1_DATA};
      end else if (eff == 2'd1) begin
        cmd_word = {`UNLOCK2_ADDR, `UNLOCK2_DATA};
      end else if (eff == 2'd2) begin
        if (kind == K_ABRT) begin
          cmd_word = {`UNLOCK1_ADDR, `CMD_RESET};
        end else if (kind == K_BUF) begin
          cmd_word = {tgt, `CMD_TO_BUFFER};
        end else begin
          cmd_word = {asp ? tgt : `UNLOCK1_ADDR, `CMD_PROGRAM};
        end
      end else if (kind == K_BUF) begin
        cmd_word = {tgt, 8'h00, count};
      end
    end
  endfunction

  // Index of the final step for a kind
  function [1:0] last_of;
    input [2:0] kind;
    input asp;
    begin
      case (kind)
        K_WORD: last_of = asp ? 2'd1 : 2'd3;
        K_BUF: last_of = 2'd3;
        K_ABRT: last_of = 2'd2;
        default: last_of = 2'd0;
      endcase
    end
  endfunction

  assign rb_sync = synced[16];
  assign dq_sync = synced[15:0];
  assign cmd_pair = cmd_word(kind_reg, step_reg, asp_reg, tgt_reg, data_reg, count_reg);
  assign last_step = (step_reg == last_of(kind_reg, asp_reg));
  assign busy = (state_reg != S_IDLE);
  assign ctrl_wr = reg_wr && (reg_addr == `REG_CTRL);
  assign line_ok = ({1'b0, tgt_reg[7:0]} + {1'b0, count_reg}) <= `LINE_LAST;

  pin_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({ready_busy_n, flash_dq_in}),
    .pin_out(synced)
  );

  bus_cycle_gen u_cycle (
    .clk(clk),
    .rst(rst),
    .start(op_start),
    .wr(op_wr),
    .addr(op_addr),
    .wdata(op_wdata),
    .dq_sync(dq_sync),
    .ready(op_ready),
    .done(op_done),
    .rdata(op_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  // Pick the bus cycle for the current state
  always @* begin
    op_wr = 1'b1;
    op_addr = cmd_pair[41:16];
    op_wdata = cmd_pair[15:0];
    op_start = 1'b0;
    if (state_reg == S_LOAD) begin
      op_addr = tgt_reg + {18'h00000, idx_reg};
      op_wdata = buf_mem[idx_reg];
    end else if (state_reg == S_CONF) begin
      op_addr = tgt_reg;
      op_wdata = `CMD_CONFIRM;
    end else if (state_reg == S_POLL) begin
      op_addr = tgt_reg;
      op_wr = 1'b0;
    end
    if ((state_reg == S_CMD || state_reg == S_LOAD || state_reg == S_CONF ||
        state_reg == S_POLL) && op_ready && !launched_reg) begin
      op_start = 1'b1;
    end
  end

  // Buffer memory loaded by software
  always @(posedge clk) begin
    if (reg_wr && reg_addr == `REG_BUF && !busy) begin
      buf_mem[wptr_reg] <= reg_wdata[15:0];
    end
  end

  // Register reads, one cycle later
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: reg_rdata <= {23'h000000, asp_reg, 8'h00};
        `REG_ADDR: reg_rdata <= {6'h00, tgt_reg};
        `REG_DATA: reg_rdata <= {16'h0000, data_reg};
        `REG_COUNT: reg_rdata <= {24'h000000, count_reg};
        `REG_BUF: reg_rdata <= {24'h000000, wptr_reg};
        `REG_STATUS: reg_rdata <= {23'h000000, st_interrupted_reg, rb_sync, suspended_reg,
          st_reset_reg, st_refused_reg, st_fail_reg, st_abort_reg, st_done_reg, busy};
        `REG_POLL: reg_rdata <= {16'h0000, poll_reg};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Command sequencer and status
  always @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      kind_reg <= K_WORD;
      step_reg <= 2'd0;
      idx_reg <= 8'h00;
      cnt_reg <= 20'h00000;
      launched_reg <= 1'b0;
      asp_reg <= 1'b0;
      suspended_reg <= 1'b0;
      tgt_reg <= 26'h0000000;
      data_reg <= 16'h0000;
      count_reg <= 8'h00;
      wptr_reg <= 8'h00;
      poll_reg <= 16'h0000;
      st_done_reg <= 1'b0;
      st_abort_reg <= 1'b0;
      st_fail_reg <= 1'b0;
      st_refused_reg <= 1'b0;
      st_reset_reg <= 1'b0;
      st_interrupted_reg <= 1'b0;
      flash_reset_n <= 1'b1;
    end else begin
      if (op_start) begin
        launched_reg <= 1'b1;
      end else if (op_done) begin
        launched_reg <= 1'b0;
      end
      // Write-one-to-clear status; hardware sets below win
      if (reg_wr && reg_addr == `REG_STATUS) begin
        st_done_reg <= st_done_reg & ~reg_wdata[1];
        st_abort_reg <= st_abort_reg & ~reg_wdata[2];
        st_fail_reg <= st_fail_reg & ~reg_wdata[3];
        st_refused_reg <= st_refused_reg & ~reg_wdata[4];
        st_reset_reg <= st_reset_reg & ~reg_wdata[5];
        st_interrupted_reg <= st_interrupted_reg & ~reg_wdata[8];
      end
      if (!busy && reg_wr) begin
        case (reg_addr)
          `REG_ADDR: tgt_reg <= reg_wdata[25:0];
          `REG_DATA: data_reg <= reg_wdata[15:0];
          `REG_COUNT: count_reg <= reg_wdata[7:0];
          default: count_reg <= count_reg;
        endcase
        if (reg_addr == `REG_COUNT) begin
          wptr_reg <= 8'h00;
        end else if (reg_addr == `REG_BUF) begin
          wptr_reg <= wptr_reg + 8'h01;
        end
        if (reg_addr == `REG_CTRL) begin
          asp_reg <= reg_wdata[`CTRL_ASP];
        end
      end
      // Hardware reset overrides everything
      if (ctrl_wr && reg_wdata[`CTRL_HRST]) begin
        st_interrupted_reg <= st_interrupted_reg | (state_reg == S_BUSY) |
          (state_reg == S_LOAD) | (state_reg == S_CONF);
        flash_reset_n <= 1'b0;
        cnt_reg <= RP_LAST;
        suspended_reg <= 1'b0;
        launched_reg <= 1'b0;
        state_reg <= S_HRST;
      end else begin
        // Outside S_BUSY every command but hardware reset is refused mid-operation
        if (ctrl_wr && busy && state_reg != S_BUSY) begin
          st_refused_reg <= 1'b1;
        end
        case (state_reg)
          S_IDLE: begin
            step_reg <= 2'd0;
            idx_reg <= 8'h00;
            if (ctrl_wr) begin
              state_reg <= S_CMD;
              if (reg_wdata[`CTRL_WORD]) begin
                kind_reg <= K_WORD;
              end else if (reg_wdata[`CTRL_BUF] && !asp_reg && line_ok) begin
                kind_reg <= K_BUF;
              end else if (reg_wdata[`CTRL_ABRT]) begin
                kind_reg <= K_ABRT;
              end else if (reg_wdata[`CTRL_CLR]) begin
                kind_reg <= K_CLR;
              end else begin
                state_reg <= S_IDLE;
                st_refused_reg <= |reg_wdata[`CTRL_RES:`CTRL_BUF];
              end
            end
          end
          S_CMD: begin
            if (op_done) begin
              step_reg <= step_reg + 2'd1;
              if (last_step) begin
                step_reg <= 2'd0;
                cnt_reg <= BUSY_SETTLE;
                if (kind_reg == K_WORD) begin
                  state_reg <= S_BUSY;
                end else if (kind_reg == K_BUF) begin
                  state_reg <= S_LOAD;
                end else if (kind_reg == K_SUSP || kind_reg == K_RES) begin
                  suspended_reg <= (kind_reg == K_SUSP);
                  state_reg <= S_BUSY;
                end else begin
                  st_done_reg <= 1'b1;
                  state_reg <= S_IDLE;
                end
              end
            end
          end
          S_LOAD: begin
            if (op_done) begin
              idx_reg <= idx_reg + 8'h01;
              if (idx_reg == count_reg) begin
                state_reg <= S_CONF;
              end
            end
          end
          S_CONF: begin
            if (op_done) begin
              cnt_reg <= BUSY_SETTLE;
              state_reg <= S_BUSY;
            end
          end
          S_BUSY: begin
            // Only suspend and resume are sent while programming
            if (ctrl_wr && (reg_wdata[`CTRL_SUSP] || reg_wdata[`CTRL_RES])) begin
              if (asp_reg || (reg_wdata[`CTRL_SUSP] == suspended_reg)) begin
                st_refused_reg <= 1'b1;
              end else begin
                kind_reg <= reg_wdata[`CTRL_SUSP] ? K_SUSP : K_RES;
                step_reg <= 2'd0;
                state_reg <= S_CMD;
              end
            end else if (ctrl_wr) begin
              st_refused_reg <= 1'b1;
            end else if (!suspended_reg) begin
              if (cnt_reg > TIMEOUT_CYC) begin
                st_fail_reg <= 1'b1;
                state_reg <= S_POLL;
              end else if (cnt_reg > BUSY_SETTLE) begin
                // Settled: count up until the synced pin reports ready
                if (rb_sync) begin
                  state_reg <= S_POLL;
                end else begin
                  cnt_reg <= cnt_reg + 20'h00001;
                end
              end else if (cnt_reg <= 20'h00001) begin
                cnt_reg <= BUSY_SETTLE + 20'h00001;
              end else begin
                cnt_reg <= cnt_reg - 20'h00001;
              end
            end
          end
          S_POLL: begin
            if (op_done) begin
              poll_reg <= op_rdata;
              step_reg <= 2'd0;
              if (op_rdata[`POLL_ABORT_BIT] && kind_reg == K_BUF) begin
                st_abort_reg <= 1'b1;
                st_fail_reg <= 1'b1;
                kind_reg <= K_ABRT;
                state_reg <= S_CMD;
              end else if (op_rdata[`POLL_TIMEOUT_BIT]) begin
                st_fail_reg <= 1'b1;
                kind_reg <= K_RST;
                state_reg <= S_CMD;
              end else begin
                st_done_reg <= 1'b1;
                state_reg <= S_IDLE;
              end
            end
          end
          S_HRST: begin
            if (cnt_reg == 20'h00000) begin
              flash_reset_n <= 1'b1;
              cnt_reg <= RPH_LAST;
              state_reg <= S_HREC;
            end else begin
              cnt_reg <= cnt_reg - 20'h00001;
            end
          end
          default: begin
            if (cnt_reg == 20'h00000) begin
              st_reset_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              cnt_reg <= cnt_reg - 20'h00001;
            end
          end
        endcase
      end
    end
  end
endmodule // flash_program_command_sequencer

// >>> flash_seq_checker_sva.sv
// Pin and register-port timing checks for the flash program sequencer.
// Assumes binding onto the sequencer top module, one clock domain.
`timescale 1ns/1ns
module flash_seq_checker (
  input wire clk,
  input wire rst,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [25:0] flash_addr,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire flash_reset_n,
  input wire [15:0] flash_dq_out,
  input wire flash_dq_oe
);
  reg [7:0] rlow_reg;
  // Cycles the flash reset has been held low
  always @(posedge clk) begin
    if (rst || flash_reset_n) rlow_reg <= 8'h00;
    else rlow_reg <= rlow_reg + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_we_pulse;
    (!flash_we_n)[*5] ##1 flash_we_n;
  endsequence
  chk_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  chk_we_select: assert property (!flash_we_n |-> !flash_ce_n && flash_reset_n)
    else $error("write strobe without chip enable");
  chk_we_hold: assert property (!flash_we_n |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  chk_we_drive: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data bus not driven during write");
  chk_oe_we_excl: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes together");
  chk_oe_release: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("bus driven during read");
  chk_reset_width: assert property ($rose(flash_reset_n) |-> rlow_reg == 8'h14)
    else $error("flash reset pulse length wrong");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // flash_seq_checker
bind flash_program_command_sequencer flash_seq_checker flash_seq_checker_inst (
  .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_reset_n(flash_reset_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe)
);

// >>> flash_device_model.sv
// Behavioural parallel NOR flash: word and buffer program, suspend, abort, reset.
// Assumes writes latch on the rising write strobe; no clock of its own.
`timescale 1ns/1ns
module flash_device_model (
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire reset_n,
  input wire [25:0] addr,
  input wire [15:0] din,
  input wire [15:0] busy_ns,
  input wire abort_next,
  input wire asp_mode,
  output reg [15:0] dout,
  output wire ready_busy_n
);
  logic [15:0] mem [int];
  logic [15:0] pend [int];
  logic [25:0] sa = 26'h0, nxt = 26'h0;
  logic busy = 1'b0, susp = 1'b0, abrt = 1'b0, fail = 1'b0;
  int st = 0, cnt = 0, n = 0, nwr = 0, left = 0;
  // Pin low while the algorithm runs, pulled up otherwise
  assign ready_busy_n = !(busy && !susp);
  task automatic fault;
    abrt = 1'b1;
    fail = 1'b1;
    st = 0;
  endtask
  task automatic go;
    busy = 1'b1;
    left = busy_ns;
    st = 0;
  endtask
  // Algorithm timer, frozen while suspended
  always #10 if (busy && !susp) begin
    left = left - 10;
    if (left <= 0) busy = 1'b0;
  end
  // Hardware reset ends any operation
  always @(negedge reset_n) begin
    busy = 1'b0;
    susp = 1'b0;
    st = 0;
  end
  // Command decoder
  always @(posedge we_n) if (!ce_n && reset_n) begin
    nwr = nwr + 1;
    if (busy) begin
      if (din == 16'h0051 && !asp_mode) susp = 1'b1;
      if (din == 16'h0050 && !asp_mode) susp = 1'b0;
    end else case (st)
      0: begin
        if (din == 16'h0071) fail = 1'b0;
        st = (din == 16'h00aa && addr == 26'h555) ? 1 : (asp_mode && din == 16'h00a0) ? 3 : 0;
      end
      1: st = (din == 16'h0055 && addr == 26'h2aa) ? 2 : 0;
      2: begin
        st = (din == 16'h00a0) ? 3 : (din == 16'h0025 && !asp_mode) ? 4 : 0;
        sa = addr;
        if (din == 16'h00f0) abrt = 1'b0;
      end
      3: begin
        mem[addr] = din;
        fail = 1'b0;
        go();
      end
      4: if (addr[25:16] != sa[25:16] || din > 16'h00ff) fault();
      else begin
        cnt = din;
        n = 0;
        pend.delete();
        st = 5;
      end
      5: if (addr[25:16] != sa[25:16] || (n > 0 && (addr != nxt || addr[7:0] == 8'h00))) fault();
      else begin
        pend[addr] = din;
        nxt = addr + 26'h1;
        n = n + 1;
        if (n > cnt) st = 6;
      end
      6: if (din != 16'h0029 || addr[25:16] != sa[25:16] || abort_next) fault();
      else begin
        foreach (pend[k]) mem[k] = pend[k];
        fail = 1'b0;
        go();
      end
    endcase
  end
  // Read gives abort status or the array word
  always @(negedge oe_n) if (!ce_n) #20 dout = abrt ? 16'h0002 : mem.exists(addr) ? mem[addr] : 16'hffff;
  // Released bus shows the inverse of the last word
  always @(posedge oe_n) dout = ~dout;
endmodule // flash_device_model

// >>> tb.sv
// Self-checking bench for the flash program sequencer against a behavioural flash.
// Assumes the sequencer register map from the shared defines.
`timescale 1ns/1ns
`include "flash_seq_defs.vh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, s;
  logic reg_wr = 1'b0, reg_rd = 1'b0, abort_next = 1'b0, asp_mode = 1'b0;
  logic [15:0] busy_ns = 16'h012c;
  wire [31:0] reg_rdata;
  wire [25:0] flash_addr;
  wire [15:0] flash_dq_out, flash_dq_in, mdl_dq;
  wire flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe, ready_busy_n;
  int num_errors = 0, num_checks = 0, cyc = 0, n0, i;
  // Bus level from whichever side drives
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : mdl_dq;
  always #5 clk = ~clk;
  flash_program_command_sequencer #(.TIMEOUT_CYC(20'h007d0)) flash_program_command_sequencer_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .ready_busy_n(ready_busy_n));
  flash_device_model flash_device_model_inst (
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
    .addr(flash_addr), .din(flash_dq_out), .busy_ns(busy_ns), .abort_next(abort_next),
    .asp_mode(asp_mode), .dout(mdl_dq), .ready_busy_n(ready_busy_n));
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 s = reg_rdata;
  endtask
  task automatic wait_done;
    int k = 0;
    rd(`REG_STATUS);
    while (!(s[0] === 1'b0 && (s[1] === 1'b1 || s[3] === 1'b1)) && k < 3000) begin
      rd(`REG_STATUS);
      k++;
    end
  endtask
  task buf_prog(input logic [25:0] a, input int c);
    wr(`REG_STATUS, 32'h13e);
    wr(`REG_ADDR, {6'h00, a});
    wr(`REG_COUNT, c);
    for (i = 0; i <= c; i++) wr(`REG_BUF, 32'h4c00 + (i << 6));
    n0 = flash_device_model_inst.nwr;
    wr(`REG_CTRL, 32'h2);
  endtask
  task word_prog(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    wr(`REG_STATUS, 32'h13e);
    wr(`REG_ADDR, a);
    wr(`REG_DATA, d);
    n0 = flash_device_model_inst.nwr;
    wr(`REG_CTRL, c);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(8'h40);
    chk(s, 32'h0);
    word_prog(32'h12340, 32'h4c0c, 32'h1);
    wait_done;
    chk(s[3:0], 4'h2);
    chk(flash_device_model_inst.nwr - n0, 4);
    chk(flash_device_model_inst.mem[26'h12340], 16'h4c0c);
    // Full aligned line, largest count
    buf_prog(26'h20100, 255);
    wait_done;
    chk(s[3:0], 4'h2);
    chk(flash_device_model_inst.nwr - n0, 261);
    for (i = 0; i < 256; i++) chk(flash_device_model_inst.mem[26'h20100 + i], 32'h4c00 + (i << 6));
    // Crossing a line is refused before any flash write
    buf_prog(26'h201fe, 2);
    repeat (20) @(posedge clk);
    rd(`REG_STATUS);
    chk(s[4], 1);
    chk(flash_device_model_inst.nwr - n0, 0);
    // Flash rejects the confirm
    abort_next <= 1'b1;
    buf_prog(26'h20300, 0);
    wait_done;
    chk(s[3:2], 2'h3);
    chk(flash_device_model_inst.abrt, 0);
    abort_next <= 1'b0;
    wr(`REG_CTRL, 32'h40);
    repeat (30) @(posedge clk);
    chk(flash_device_model_inst.fail, 0);
    // Suspend, refused command, resume
    busy_ns <= 16'h1f40;
    word_prog(32'h12350, 32'h4c10, 32'h1);
    repeat (100) @(posedge clk);
    wr(`REG_CTRL, 32'h10);
    wr(`REG_CTRL, 32'h40);
    repeat (30) @(posedge clk);
    rd(`REG_STATUS);
    chk({s[6], s[4]}, 2'h3);
    chk(flash_device_model_inst.susp, 1);
    wr(`REG_CTRL, 32'h20);
    wait_done;
    chk(s[3:0], 4'h2);
    chk(flash_device_model_inst.mem[26'h12350], 16'h4c10);
    // Protection-space word program without unlocks
    busy_ns <= 16'h012c;
    asp_mode <= 1'b1;
    wr(`REG_CTRL, 32'h100);
    word_prog(32'h400, 32'h4c14, 32'h101);
    wait_done;
    chk(flash_device_model_inst.nwr - n0, 2);
    chk(flash_device_model_inst.mem[26'h400], 16'h4c14);
    rd(`REG_CTRL);
    chk(s[8], 1);
    asp_mode <= 1'b0;
    wr(`REG_CTRL, 32'h0);
    // Hardware reset and recovery
    wr(`REG_STATUS, 32'h13e);
    wr(`REG_CTRL, 32'h8);
    repeat (3600) @(posedge clk);
    rd(`REG_STATUS);
    chk(s[5], 1);
    end_sim;
  end
endmodule // tb
